// *** common/fwsr_pkg.sv ***
// Shared constants and types of the flash write-status polling controller
package fwsr_pkg;
	// Clock and flash timing
	localparam int CLK_NS = 100; // System clock period
	localparam int T_ACC_NS = 90; // Slowest flash read access time
	localparam int STRB_CYC = ((T_ACC_NS + CLK_NS - 1) / CLK_NS < 1) ? 1 : (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int FL_ADDR_W = 19; // Flash address width
	// Register offsets (byte addresses)
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ADDR = 8'h04;
	localparam logic [7:0] OFF_WDATA = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_RDATA = 8'h10;
	// Control register fields
	localparam int CTRL_OP_LSB = 0; // Three-bit operation code
	localparam int CTRL_SEL = 3; // 0: progress toggle, 1: sector toggle
	localparam int CTRL_IGN = 4; // Skip erase-window checks
	localparam int CTRL_ABORT = 5; // Break off polling
	// Operation codes
	localparam logic [2:0] OP_NONE = 3'h0;
	localparam logic [2:0] OP_READ = 3'h1;
	localparam logic [2:0] OP_WRITE = 3'h2;
	localparam logic [2:0] OP_POLL = 3'h3;
	localparam logic [2:0] OP_RESET = 3'h4;
	localparam logic [2:0] OP_ERASE_ADD = 3'h5;
	// Status register fields
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_OK = 2;
	localparam int ST_FAIL = 3;
	localparam int ST_REJ = 4;
	localparam int ST_TMO = 5;
	// Flash status bit positions and commands
	localparam int POLL_BIT = 7; // poll_complement_bit
	localparam int PROG_TGL_BIT = 6; // progress_toggle_bit
	localparam int TMO_BIT = 5; // timeout_fail_flag
	localparam int WIN_BIT = 3; // erase_window_bit
	localparam int SECT_TGL_BIT = 2; // sector_toggle_bit
	localparam logic [7:0] RESET_CMD = 8'hF0;
	// Controller states, Gray along the polling path
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_P_RD1 = 4'h1,
		ST_P_RD2 = 4'h3,
		ST_P_RD3 = 4'h2,
		ST_P_RD4 = 4'h6,
		ST_RST_WR = 4'h7,
		ST_SINGLE = 4'h5,
		ST_W_PRE = 4'h4,
		ST_W_CMD = 4'hC,
		ST_W_POST = 4'hD
	} fwsr_state_t;
	// Bus cycle engine states
	typedef enum logic [1:0] {
		E_IDLE = 2'h0,
		E_SETUP = 2'h1,
		E_STRB = 2'h3,
		E_HOLD = 2'h2
	} fwsr_cyc_t;
endpackage

// *** hw/fwsr_cycle.sv ***
// Single flash bus cycle generator (read or write) on the chip-enable/output-enable/write-enable pins
`timescale 1ns/100ps
module fwsr_cycle import fwsr_pkg::*; #(
	parameter int ADDR_W = FL_ADDR_W,
	parameter int STRB_N = STRB_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic wr,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [7:0] wdata_in,
	output logic done,
	output logic [7:0] rdata,
	output logic [ADDR_W-1:0] fl_addr,
	input wire logic [7:0] fl_dq_i,
	output logic [7:0] fl_dq_o,
	output logic fl_dq_oe,
	output logic fl_ce_b,
	output logic fl_oe_b,
	output logic fl_we_b
);
	fwsr_cyc_t e_q, e_d; // Cycle phase
	logic [3:0] cnt_q, cnt_d; // Strobe width counter
	logic wr_q, wr_d; // Direction of the current cycle
	logic [ADDR_W-1:0] addr_q, addr_d; // Latched address
	logic [7:0] dout_q, dout_d; // Latched write data
	logic [7:0] rdata_q, rdata_d; // Captured read data
	logic ce_b_q, ce_b_d, oe_b_q, oe_b_d, we_b_q, we_b_d, dq_oe_q, dq_oe_d;

	// Next phase; chip enable drops every cycle so each read is a fresh strobe for the toggle bits
	always_comb begin
		e_d = e_q;
		cnt_d = cnt_q;
		wr_d = wr_q;
		addr_d = addr_q;
		dout_d = dout_q;
		rdata_d = rdata_q;
		ce_b_d = ce_b_q;
		oe_b_d = oe_b_q;
		we_b_d = we_b_q;
		dq_oe_d = dq_oe_q;
		case (e_q)
			E_IDLE: begin
				// Latch the request and drop chip enable; address settles one cycle before the output- or write-enable strobe
				if (start) begin
					wr_d = wr;
					addr_d = addr_in;
					dout_d = wdata_in;
					ce_b_d = 1'b0;
					dq_oe_d = wr;
					e_d = E_SETUP;
				end
			end
			E_SETUP: begin
				oe_b_d = wr_q;
				we_b_d = !wr_q;
				cnt_d = 4'(STRB_N - 1);
				e_d = E_STRB;
			end
			E_STRB: begin
				// Sample at the end of the strobe, after the access time
				if (cnt_q == 4'h0) begin
					oe_b_d = 1'b1;
					we_b_d = 1'b1;
					if (!wr_q) begin
						rdata_d = fl_dq_i;
					end
					e_d = E_HOLD;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			default: begin
				// Data held one cycle past the write-enable rise
				ce_b_d = 1'b1;
				dq_oe_d = 1'b0;
				e_d = E_IDLE;
			end
		endcase
	end

	// Phase registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			e_q <= E_IDLE;
			cnt_q <= 4'h0;
			wr_q <= 1'b0;
			addr_q <= '0;
			dout_q <= 8'h00;
			rdata_q <= 8'h00;
			ce_b_q <= 1'b1;
			oe_b_q <= 1'b1;
			we_b_q <= 1'b1;
			dq_oe_q <= 1'b0;
		end else begin
			e_q <= e_d;
			cnt_q <= cnt_d;
			wr_q <= wr_d;
			addr_q <= addr_d;
			dout_q <= dout_d;
			rdata_q <= rdata_d;
			ce_b_q <= ce_b_d;
			oe_b_q <= oe_b_d;
			we_b_q <= we_b_d;
			dq_oe_q <= dq_oe_d;
		end
	end

	assign done = (e_q == E_HOLD); // One-cycle end of cycle
	assign rdata = rdata_q;
	assign fl_addr = addr_q;
	assign fl_dq_o = dout_q;
	assign fl_dq_oe = dq_oe_q;
	assign fl_ce_b = ce_b_q;
	assign fl_oe_b = oe_b_q;
	assign fl_we_b = we_b_q;

	// Never drive the data pins while the flash may be driving them
	a_no_contention: assert property (@(posedge clk) disable iff (!rst_b)
		!(fl_dq_oe && !fl_oe_b)) else $error("data pins driven during output enable");
endmodule

// *** hw/fwsr_host.sv ***
// APB-controlled host that runs flash status polling, reset and sector erase add sequences
//
// Contract
// [R1] Progress toggle readable at any address
// [R2] Progress bit inverts each read while busy
// [R3] All-protected erase toggles about 100 us
// [R4] Partly protected erase skips protected sectors
// [R5] Erase suspend stops progress toggling
// [R6] Protected program toggles about 2 us
// [R7] Suspend-program toggles until program completes
// [R8] Sector toggle inverts in erasing sectors
// [R9] Sector toggle same for suspended sectors
// [R10] Host polls at a valid address
// [R11] Host does two back-to-back status reads
// [R12] Steady toggle bit means operation complete
// [R13] Toggling with timeout: recheck, else reset
// [R14] Resumed polling restarts from double read
// [R15] Timeout flag set on pulse limit
// [R16] Programming one over zero times out
// [R17] After timeout failure host writes reset
// [R18] Erase window bit low during time-out
// [R19] Each sector command restarts time-out
// [R20] Window ignorable if commands under 50 us
// [R21] Window high: only suspend accepted
// [R22] Check window bit before and after command
// [R23] Poll bit reflects erase or program state
// [R24] Reset is one write of F0
// [R25] Non-suspended sectors read array data
// [R26] Idle reads return array contents
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module fwsr_host import fwsr_pkg::*; #(
	parameter int ADDR_W = FL_ADDR_W
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [ADDR_W-1:0] fl_addr,
	input wire logic [7:0] fl_dq_i,
	output logic [7:0] fl_dq_o,
	output logic fl_dq_oe,
	output logic fl_ce_b,
	output logic fl_oe_b,
	output logic fl_we_b
);
	// Software-visible settings
	logic sel_q, sel_d; // Which toggle bit to watch
	logic ign_q, ign_d; // Skip erase-window checks
	logic [ADDR_W-1:0] addr_q, addr_d; // Flash target address
	logic [7:0] wdata_q, wdata_d; // Flash write byte
	logic [31:0] prdata_q, prdata_d; // Read data, captured in setup
	logic pslverr_q, pslverr_d; // Unmapped address flag
	// Sequencer state
	fwsr_state_t state_q, state_d;
	logic start_q, start_d; // Launches one flash cycle
	logic cyc_wr_q, cyc_wr_d; // Direction of that cycle
	logic [7:0] cyc_wdata_q, cyc_wdata_d; // Byte for that cycle
	logic first_q, first_d; // Toggle bit stored from the first read
	logic abort_q, abort_d; // Polling break-off request
	logic [7:0] rdata_q, rdata_d; // Last flash byte read
	logic done_q, done_d, ok_q, ok_d, fail_q, fail_d, rej_q, rej_d, tmo_q, tmo_d;
	// Engine handshake
	logic cyc_done; // One-cycle end of a flash cycle
	logic [7:0] cyc_rdata; // Byte captured by the engine
	logic apb_wr; // Write taking effect this edge
	logic wr_ctrl; // Control register written
	logic [2:0] op; // Requested operation
	logic tb_now; // Watched toggle bit of the latest read

	// Toggle bit selection: progress bit for whole-device status, sector bit for one sector
	function automatic logic tbit(input logic [7:0] d, input logic s);
		return s ? d[SECT_TGL_BIT] : d[PROG_TGL_BIT];
	endfunction

	assign pready = psel && penable; // Zero wait states
	assign apb_wr = psel && penable && pwrite;
	assign wr_ctrl = apb_wr && (paddr == OFF_CTRL);
	assign op = pwdata[CTRL_OP_LSB +: 3];
	assign tb_now = tbit(cyc_rdata, sel_q);

	// Register file: writes in access phase, read data and error captured in setup phase
	always_comb begin
		sel_d = sel_q;
		ign_d = ign_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		prdata_d = prdata_q;
		pslverr_d = pslverr_q;
		if (psel && !penable) begin
			prdata_d = 32'h0000_0000;
			pslverr_d = 1'b0;
			if (paddr == OFF_CTRL) begin
				prdata_d[CTRL_SEL] = sel_q;
				prdata_d[CTRL_IGN] = ign_q;
			end else if (paddr == OFF_ADDR) begin
				prdata_d[ADDR_W-1:0] = addr_q;
			end else if (paddr == OFF_WDATA) begin
				prdata_d[7:0] = wdata_q;
			end else if (paddr == OFF_STATUS) begin
				prdata_d[ST_BUSY] = (state_q != ST_IDLE);
				prdata_d[ST_DONE] = done_q;
				prdata_d[ST_OK] = ok_q;
				prdata_d[ST_FAIL] = fail_q;
				prdata_d[ST_REJ] = rej_q;
				prdata_d[ST_TMO] = tmo_q;
			end else if (paddr == OFF_RDATA) begin
				prdata_d[7:0] = rdata_q;
			end else begin
				pslverr_d = 1'b1;
			end
		end
		// Settings are frozen while a sequence runs so it stays self-consistent
		if (apb_wr && (state_q == ST_IDLE)) begin
			if (paddr == OFF_CTRL) begin
				sel_d = pwdata[CTRL_SEL];
				ign_d = pwdata[CTRL_IGN];
			end else if (paddr == OFF_ADDR) begin
				addr_d = pwdata[ADDR_W-1:0];
			end else if (paddr == OFF_WDATA) begin
				wdata_d = pwdata[7:0];
			end
		end
	end

	// Register file flops
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sel_q <= 1'b0;
			ign_q <= 1'b0;
			addr_q <= '0;
			wdata_q <= 8'h00;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			sel_q <= sel_d;
			ign_q <= ign_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata = prdata_q;
	assign pslverr = pslverr_q && psel && penable;

	// Sequencer: each state launches one flash cycle and moves on when it ends
	always_comb begin
		state_d = state_q;
		start_d = 1'b0;
		cyc_wr_d = cyc_wr_q;
		cyc_wdata_d = cyc_wdata_q;
		first_d = first_q;
		abort_d = abort_q || (wr_ctrl && pwdata[CTRL_ABORT]);
		rdata_d = rdata_q;
		done_d = done_q;
		ok_d = ok_q;
		fail_d = fail_q;
		rej_d = rej_q;
		tmo_d = tmo_q;
		case (state_q)
			ST_IDLE: begin
				abort_d = 1'b0;
				if (wr_ctrl && (op != OP_NONE) && (op <= OP_ERASE_ADD)) begin
					done_d = 1'b0;
					ok_d = 1'b0;
					fail_d = 1'b0;
					rej_d = 1'b0;
					tmo_d = 1'b0;
					start_d = 1'b1;
					cyc_wr_d = 1'b0;
					cyc_wdata_d = wdata_q;
					if (op == OP_READ) begin
						state_d = ST_SINGLE;
					end else if (op == OP_WRITE) begin
						cyc_wr_d = 1'b1;
						state_d = ST_SINGLE;
					end else if (op == OP_POLL) begin
						// Polling always opens with a fresh double read
						state_d = ST_P_RD1; // R14
					end else if (op == OP_RESET) begin
						cyc_wr_d = 1'b1;
						cyc_wdata_d = RESET_CMD; // R24
						state_d = ST_RST_WR;
					end else if (pwdata[CTRL_IGN]) begin
						// Caller promises commands closer than the window time-out
						cyc_wr_d = 1'b1; // R20
						state_d = ST_W_CMD;
					end else begin
						state_d = ST_W_PRE; // R22
					end
				end
			end
			ST_P_RD1: begin
				// Store the toggle bit of the first read, read again at once
				if (cyc_done) begin
					first_d = tb_now; // R11
					start_d = 1'b1;
					state_d = ST_P_RD2;
				end
			end
			ST_P_RD2: begin
				if (cyc_done) begin
					rdata_d = cyc_rdata;
					tmo_d = cyc_rdata[TMO_BIT];
					if (tb_now == first_q) begin
						// Steady bit: finished, next read already gives array data
						ok_d = 1'b1; // R12
						done_d = 1'b1;
						state_d = ST_IDLE;
					end else if (cyc_rdata[TMO_BIT]) begin
						// Bit may have stopped just as the flag rose: look once more
						start_d = 1'b1; // R13
						state_d = ST_P_RD3;
					end else if (abort_q) begin
						state_d = ST_IDLE; // R14
					end else begin
						// Still busy, keep monitoring from the top
						start_d = 1'b1; // R14
						state_d = ST_P_RD1;
					end
				end
			end
			ST_P_RD3: begin
				if (cyc_done) begin
					first_d = tb_now; // R13
					start_d = 1'b1;
					state_d = ST_P_RD4;
				end
			end
			ST_P_RD4: begin
				if (cyc_done) begin
					rdata_d = cyc_rdata;
					if (tb_now == first_q) begin
						ok_d = 1'b1; // R13
						done_d = 1'b1;
						state_d = ST_IDLE;
					end else begin
						// Failed operation leaves the device in status mode
						fail_d = 1'b1; // R17
						start_d = 1'b1;
						cyc_wr_d = 1'b1;
						cyc_wdata_d = RESET_CMD; // R24
						state_d = ST_RST_WR;
					end
				end
			end
			ST_RST_WR: begin
				if (cyc_done) begin
					ok_d = !fail_q;
					done_d = 1'b1;
					state_d = ST_IDLE;
				end
			end
			ST_SINGLE: begin
				if (cyc_done) begin
					if (!cyc_wr_q) begin
						rdata_d = cyc_rdata;
					end
					ok_d = 1'b1;
					done_d = 1'b1;
					state_d = ST_IDLE;
				end
			end
			ST_W_PRE: begin
				// Window already closed: the device would ignore the command
				if (cyc_done) begin
					rdata_d = cyc_rdata;
					if (cyc_rdata[WIN_BIT]) begin
						rej_d = 1'b1; // R22
						done_d = 1'b1;
						state_d = ST_IDLE;
					end else begin
						start_d = 1'b1;
						cyc_wr_d = 1'b1;
						state_d = ST_W_CMD;
					end
				end
			end
			ST_W_CMD: begin
				if (cyc_done) begin
					if (ign_q) begin
						ok_d = 1'b1; // R20
						done_d = 1'b1;
						state_d = ST_IDLE;
					end else begin
						start_d = 1'b1; // R22
						cyc_wr_d = 1'b0;
						state_d = ST_W_POST;
					end
				end
			end
			default: begin
				// High after the command: it may have come too late
				if (cyc_done) begin
					rdata_d = cyc_rdata;
					rej_d = cyc_rdata[WIN_BIT]; // R22
					ok_d = !cyc_rdata[WIN_BIT];
					done_d = 1'b1;
					state_d = ST_IDLE;
				end
			end
		endcase
	end

	// Sequencer flops
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_IDLE;
			start_q <= 1'b0;
			cyc_wr_q <= 1'b0;
			cyc_wdata_q <= 8'h00;
			first_q <= 1'b0;
			abort_q <= 1'b0;
			rdata_q <= 8'h00;
			done_q <= 1'b0;
			ok_q <= 1'b0;
			fail_q <= 1'b0;
			rej_q <= 1'b0;
			tmo_q <= 1'b0;
		end else begin
			state_q <= state_d;
			start_q <= start_d;
			cyc_wr_q <= cyc_wr_d;
			cyc_wdata_q <= cyc_wdata_d;
			first_q <= first_d;
			abort_q <= abort_d;
			rdata_q <= rdata_d;
			done_q <= done_d;
			ok_q <= ok_d;
			fail_q <= fail_d;
			rej_q <= rej_d;
			tmo_q <= tmo_d;
		end
	end

	// Flash cycle engine, always aimed at the software-chosen address
	fwsr_cycle #(.ADDR_W(ADDR_W), .STRB_N(STRB_CYC)) u_cycle (
		.clk(clk),
		.rst_b(rst_b),
		.start(start_q),
		.wr(cyc_wr_q),
		.addr_in(addr_q), // R10
		.wdata_in(cyc_wdata_q),
		.done(cyc_done),
		.rdata(cyc_rdata),
		.fl_addr(fl_addr),
		.fl_dq_i(fl_dq_i),
		.fl_dq_o(fl_dq_o),
		.fl_dq_oe(fl_dq_oe),
		.fl_ce_b(fl_ce_b),
		.fl_oe_b(fl_oe_b),
		.fl_we_b(fl_we_b)
	);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_rd1_done;
		(state_q == ST_P_RD1) && cyc_done;
	endsequence
	sequence s_rd2_done;
		(state_q == ST_P_RD2) && cyc_done;
	endsequence
	sequence s_rd4_fail;
		(state_q == ST_P_RD4) && cyc_done && (tb_now != first_q);
	endsequence

	a_poll_addr: assert property ((state_q inside {ST_P_RD1, ST_P_RD2, ST_P_RD3, ST_P_RD4}) && !fl_ce_b |-> // R10
		(fl_addr == addr_q)) else $error("poll read not at target address");
	a_double_read: assert property (s_rd1_done |=> (state_q == ST_P_RD2) && start_q && !cyc_wr_q) // R11
		else $error("second status read not issued");
	a_steady_done: assert property (s_rd2_done ##0 (tb_now == first_q) |=> // R12
		(state_q == ST_IDLE) && ok_q && done_q) else $error("steady toggle not reported complete");
	a_tmo_recheck: assert property (s_rd2_done ##0 (tb_now != first_q) && cyc_rdata[TMO_BIT] |=> // R13
		(state_q == ST_P_RD3) && tmo_q ##1 !fl_ce_b [*2]) else $error("no recheck after timeout flag");
	a_poll_restart: assert property (s_rd2_done ##0 (tb_now != first_q) && !cyc_rdata[TMO_BIT] && !abort_q |=> // R14
		(state_q == ST_P_RD1) && start_q) else $error("monitoring did not restart at first read");
	a_fail_reset: assert property (s_rd4_fail |=> (state_q == ST_RST_WR) ##[1:20] // R17
		((state_q == ST_IDLE) && fail_q && done_q)) else $error("failure not followed by reset write");
	a_reset_byte: assert property (!fl_we_b && (state_q == ST_RST_WR) |-> fl_dq_oe && (fl_dq_o == RESET_CMD)) // R24
		else $error("reset write carries wrong byte");
	a_win_skip: assert property ((state_q == ST_W_CMD) && cyc_done && ign_q |=> (state_q == ST_IDLE) && ok_q) // R20
		else $error("window check not skipped");
	a_win_post: assert property ((state_q == ST_W_CMD) && cyc_done && !ign_q |=> // R22
		(state_q == ST_W_POST) && !cyc_wr_q) else $error("window not rechecked after command");
endmodule

// *** sim/fwsr_flash.sv ***
// Behavioural flash device answering status and array reads
`timescale 1ns/100ps
module fwsr_flash import fwsr_pkg::*; (
	input wire logic clk,
	input wire logic [FL_ADDR_W-1:0] fl_addr,
	output logic [7:0] fl_dq_i,
	input wire logic [7:0] fl_dq_o,
	input wire logic fl_ce_b,
	input wire logic fl_oe_b,
	input wire logic fl_we_b,
	input wire logic ld,
	input wire logic [7:0] ld_rds,
	input wire logic ld_stuck,
	input wire logic ld_tmo,
	input wire logic ld_susp,
	input wire logic [7:0] ld_win,
	output logic [15:0] n_rd,
	output logic [15:0] n_wr
);
	logic [7:0] left_q = 8'h00; // Toggling reads still to come
	logic stuck_q = 1'b0; // Halted operation toggles until reset
	logic tmo_q = 1'b0; // Pulse limit exceeded
	logic susp_q = 1'b0; // Erase suspended
	logic [7:0] win_q = 8'h00; // Reads until the window closes
	logic [7:0] wlen_q = 8'h00; // Window restart length
	logic pt_q = 1'b0; // progress_toggle_bit
	logic st_q = 1'b0; // sector_toggle_bit
	logic [7:0] last_q = 8'h00; // Last byte driven
	logic [7:0] cur; // Byte offered on this read
	logic rd_p = 1'b0; // Read strobe level at the previous edge
	logic we_p = 1'b1; // Write strobe level at the previous edge
	wire busy = (left_q != 8'h00) || stuck_q;
	// Sector 2 is the one selected for erasure
	wire in_sect = (fl_addr[18:16] == 3'h2) && (busy || susp_q);
	wire rd_en = !fl_ce_b && !fl_oe_b;
	// Status while busy, suspend status in the sector, else array
	always_comb begin
		if (busy) begin
			cur = {1'b0, pt_q, tmo_q, 1'b0, win_q == 8'h00, st_q, 2'h0};
		end else if (susp_q && in_sect) begin
			cur = {1'b1, pt_q, 3'h0, st_q, 2'h0};
		end else begin
			cur = fl_addr[7:0] ^ 8'h85;
		end
	end
	// Released bus must not look like held data, so show the inverse
	assign fl_dq_i = rd_en ? cur : ~last_q;
	// Strobe ends and loads are seen at the bench clock, so each state has a single driver
	always @(posedge clk) begin
		rd_p <= rd_en;
		we_p <= fl_we_b;
		if (ld) begin
			// Scenario load from the bench
			left_q <= ld_rds;
			stuck_q <= ld_stuck;
			tmo_q <= ld_tmo;
			susp_q <= ld_susp;
			win_q <= ld_win;
			wlen_q <= ld_win;
			pt_q <= 1'b0;
			st_q <= 1'b0;
			n_rd <= 16'h0000;
			n_wr <= 16'h0000;
		end else if (rd_p && !rd_en) begin
			// End of a read cycle, by either strobe, advances the toggles
			last_q <= cur;
			n_rd <= n_rd + 16'h0001;
			if (busy && !susp_q) pt_q <= ~pt_q;
			if (in_sect) st_q <= ~st_q;
			if (left_q != 8'h00) left_q <= left_q - 8'h01;
			if (win_q != 8'h00) win_q <= win_q - 8'h01;
		end else if (!we_p && fl_we_b && !fl_ce_b) begin
			// Host writes: reset command or a further sector erase command
			n_wr <= n_wr + 16'h0001;
			if (fl_dq_o == RESET_CMD) begin
				left_q <= 8'h00;
				stuck_q <= 1'b0;
				tmo_q <= 1'b0;
				susp_q <= 1'b0;
			end else if (fl_dq_o == 8'h30 && win_q != 8'h00) begin
				win_q <= wlen_q;
			end
		end
	end
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the flash status polling controller
`timescale 1ns/100ps
module tb_top import fwsr_pkg::*; ;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic [18:0] fl_addr;
	logic [7:0] fl_dq_i, fl_dq_o;
	logic fl_dq_oe, fl_ce_b, fl_oe_b, fl_we_b;
	logic ld = 1'b0; // Model load strobe
	logic [7:0] ld_rds = 8'h00;
	logic ld_stuck = 1'b0;
	logic ld_tmo = 1'b0;
	logic ld_susp = 1'b0;
	logic [7:0] ld_win = 8'h00;
	logic [15:0] n_rd, n_wr; // Flash cycles seen by the model
	logic [31:0] rd_q; // Last APB read data
	logic err_q; // Last APB error flag
	int n_mismatch = 0;
	int comparisons = 0;
	// One polling or erase-add case: model setup, request, expected result
	typedef struct {
		logic [7:0] rds; logic stuck; logic tmo; logic susp; logic [7:0] win;
		logic [18:0] addr; logic [7:0] ctrl; logic [5:0] st; logic [3:0] nr; logic [3:0] nw;
	} fwsr_row_t;
	fwsr_row_t rows [11] = '{
		'{8'h00, 1'h0, 1'h0, 1'h0, 8'h00, 19'h20010, 8'h03, 6'h06, 4'h2, 4'h0},
		'{8'h05, 1'h0, 1'h0, 1'h0, 8'h00, 19'h20010, 8'h03, 6'h06, 4'h6, 4'h0},
		'{8'h02, 1'h0, 1'h1, 1'h0, 8'h00, 19'h20010, 8'h03, 6'h26, 4'h4, 4'h0},
		'{8'h00, 1'h1, 1'h1, 1'h0, 8'h00, 19'h20010, 8'h03, 6'h2A, 4'h4, 4'h1},
		'{8'h00, 1'h0, 1'h0, 1'h1, 8'h00, 19'h20010, 8'h03, 6'h06, 4'h2, 4'h0},
		'{8'h00, 1'h0, 1'h0, 1'h1, 8'h00, 19'h50010, 8'h0B, 6'h06, 4'h2, 4'h0},
		'{8'h03, 1'h0, 1'h0, 1'h0, 8'h00, 19'h50010, 8'h0B, 6'h06, 4'h2, 4'h0},
		'{8'h03, 1'h0, 1'h0, 1'h0, 8'h00, 19'h20010, 8'h0B, 6'h06, 4'h6, 4'h0},
		'{8'h32, 1'h0, 1'h0, 1'h0, 8'h00, 19'h20000, 8'h05, 6'h12, 4'h1, 4'h0},
		'{8'h32, 1'h0, 1'h0, 1'h0, 8'h04, 19'h20000, 8'h05, 6'h06, 4'h2, 4'h1},
		'{8'h32, 1'h0, 1'h0, 1'h0, 8'h04, 19'h20000, 8'h15, 6'h06, 4'h0, 4'h1}
	};
	fwsr_host fwsr_host_i (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .fl_addr, .fl_dq_i, .fl_dq_o, .fl_dq_oe, .fl_ce_b, .fl_oe_b, .fl_we_b);
	fwsr_flash fwsr_flash_i (.clk, .fl_addr, .fl_dq_i, .fl_dq_o, .fl_ce_b, .fl_oe_b, .fl_we_b, .ld, .ld_rds,
		.ld_stuck, .ld_tmo, .ld_susp, .ld_win, .n_rd, .n_wr);
	// Verdict and end of run
	task automatic wrap_up();
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Compare one value and count it
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer; holds the request until pready is seen
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			n_mismatch++;
			wrap_up();
		end
	endtask
	// Poll STATUS until the controller is idle, bounded
	task automatic wait_idle();
		int n;
		n = 0;
		rd_q = 32'h1;
		while (rd_q[ST_BUSY] !== 1'b0 && n < 200) begin
			apb(1'b0, OFF_STATUS, 32'h0);
			n++;
		end
		if (n >= 200) begin
			n_mismatch++;
			wrap_up();
		end
	endtask
	// Set up the flash model for the next case
	task automatic load(input logic [7:0] r, input logic s, input logic t, input logic p, input logic [7:0] w);
		@(posedge clk);
		ld_rds <= r;
		ld_stuck <= s;
		ld_tmo <= t;
		ld_susp <= p;
		ld_win <= w;
		@(posedge clk);
		ld <= 1'b1;
		@(posedge clk);
		ld <= 1'b0;
	endtask
	// Start an operation and wait until it ends
	task automatic run_op(input logic [31:0] c);
		apb(1'b1, OFF_CTRL, c);
		wait_idle();
	endtask
	initial begin
		forever #50 clk = ~clk;
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		chk("pins", 32'hE, {28'h0, fl_ce_b, fl_oe_b, fl_we_b, fl_dq_oe});
		apb(1'b0, OFF_STATUS, 32'h0);
		chk("status", 32'h0, rd_q);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped", 32'h1, {rd_q[30:0], err_q});
		apb(1'b1, OFF_CTRL, 32'h18);
		apb(1'b0, OFF_CTRL, 32'h0);
		chk("ctrl", 32'h18, rd_q);
		apb(1'b1, OFF_WDATA, 32'h30);
		// Table of polling and erase-add cases
		foreach (rows[i]) begin
			load(rows[i].rds, rows[i].stuck, rows[i].tmo, rows[i].susp, rows[i].win);
			apb(1'b1, OFF_ADDR, {13'h0, rows[i].addr});
			run_op({24'h0, rows[i].ctrl});
			chk("status", {26'h0, rows[i].st}, rd_q);
			chk("cycles", {12'h0, rows[i].nr, 12'h0, rows[i].nw}, {n_rd, n_wr});
		end
		// Break off an endless poll: no done, whole pairs only
		load(8'h00, 1'h1, 1'h0, 1'h0, 8'h00);
		apb(1'b1, OFF_CTRL, 32'h03);
		repeat (30) @(posedge clk);
		run_op(32'h23);
		chk("abort", 32'h0, {rd_q[31:1], n_rd[0]});
		// Reset op, then a single read returns array data
		load(8'h00, 1'h1, 1'h1, 1'h0, 8'h00);
		apb(1'b1, OFF_ADDR, 32'h20033);
		run_op(32'h04);
		run_op(32'h01);
		apb(1'b0, OFF_RDATA, 32'h0);
		chk("rdata", 32'hB6, rd_q);
		apb(1'b1, OFF_WDATA, 32'hF0);
		run_op(32'h02);
		chk("cycles", 32'h00010002, {n_rd, n_wr});
		wrap_up();
	end
endmodule
